// file: design/memctl_cfg.svh
// Register offsets, field positions, encodings and reset values of the memory controller
`ifndef MEMCTL_CFG_SVH
`define MEMCTL_CFG_SVH

// ====================================================================
// Register offsets (byte addresses on the register bus)
`define REMAP_CTRL_OFF 8'h00
`define ABORT_STAT_OFF 8'h04
`define ABORT_ADDR_OFF 8'h08
`define PROT_AREA_FIRST_OFF 8'h10
`define PROT_AREA_LAST_OFF 8'h4C
`define PROT_PERIPH_OFF 8'h50
`define PROT_ENABLE_OFF 8'h54
`define BOOT_SELECT_OFF 8'h58

// ====================================================================
// Abort status field positions
`define ASR_UNDEF_BIT 0
`define ASR_MISALIGN_BIT 1
`define ASR_PROT_BIT 2
`define ASR_SIZE_LSB 8
`define ASR_TYPE_LSB 10
`define ASR_SRC_LSB 16
`define ASR_STICKY_LSB 24

// ====================================================================
// Protection area layout and reset values
`define PA_PROT_LSB 0
`define PA_SIZE_LSB 4
`define PA_BASE_LSB 10
`define PA_RW_MASK 32'h003F_FCF3
`define PA_SIZE_MAX 4'hC
`define PROT_RESET 32'h0000_0000

// ====================================================================
// Address map: top nibble and internal 1-Mbyte slots
`define TOP_INTERNAL 4'h0
`define TOP_EBI_FIRST 4'h1
`define TOP_EBI_LAST 4'h8
`define TOP_PERIPH 4'hF
`define SLOT_AREA0 8'h00
`define SLOT_FLASH 8'h01
`define SLOT_SRAM 8'h02
`define SLOT_ROM 8'h03

// ====================================================================
// Encodings of size, access type and protection level
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define TYPE_READ 2'h0
`define TYPE_WRITE 2'h1
`define TYPE_FETCH 2'h2
`define PROT_NONE 2'h0
`define PROT_PRIV 2'h1
`define PROT_USER_RO 2'h2
`define PROT_FULL 2'h3

`endif

// file: design/memctl_pkg.sv
// Types shared by the memory controller
package memctl_pkg;

    // ================================================================
    // Address region classes
    typedef enum logic [3:0] {
        REGION_INTERNAL = 4'b0001,
        REGION_EXTERNAL = 4'b0010,
        REGION_PERIPH = 4'b0100,
        REGION_UNDEF = 4'b1000
    } region_e;

    typedef logic [1:0] prot_t;

endpackage : memctl_pkg

// file: design/memory_controller.sv
// System bus memory controller: arbiter, address decoder, protection, abort status
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "memctl_cfg.svh"

// Notes on behaviour
// - DMA master always wins over processor
// - Top four address bits pick ten regions
// - Internal, peripheral and eight chip-select regions
// - Undefined 1536M space answers with abort
// - Eight more bits pick 1-Mbyte memory slots
// - Each memory aliases across its whole slot
// - Unassigned internal slot answers with abort
// - Area 0 boots ROM or flash by bit
// - Erase input clears the boot-select bit
// - Remapped area 0 shows SRAM, originals stay
// - Writing one toggles remap, zero ignored
// - Abort causes: undefined, protection, misaligned only
// - Abort goes to all masters; processor acts
// - Abort captures full 32-bit access address
// - Status records size and access type
// - Separate undefined, misaligned, protection indicators
// - One source bit per master
// - Sticky per-master flag for overwritten aborts
// - Data abort stores data address, not instruction
// - Little-endian transfers only
// - Sixteen protection areas plus peripheral protection
// - Misaligned word/half aborts; fetches exempt
// - Enabled unit aborts internal accesses outside areas; strongest wins
module memory_controller
    import memctl_pkg::*;
#(
    parameter int N_AREAS = 16,
    parameter int FLASH_AW = 19,
    parameter int SRAM_AW = 15,
    parameter int ROM_AW = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor master
    input wire logic cpu_req,
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_write,
    input wire logic [1:0] cpu_size,
    input wire logic cpu_fetch,
    input wire logic cpu_priv,
    output logic cpu_gnt,
    // Peripheral DMA master
    input wire logic dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic dma_write,
    input wire logic [1:0] dma_size,
    input wire logic dma_priv,
    output logic dma_gnt,
    // Flash erase strobe
    input wire logic erase_in,
    // Decoded transfer towards the slaves
    output logic xfer_valid,
    output logic xfer_master,
    output logic xfer_write,
    output logic [1:0] xfer_size,
    output logic [31:0] xfer_addr,
    output logic [2:0] mem_sel,
    output logic [7:0] ebi_cs,
    output logic periph_sel,
    // Abort to all masters and map status
    output logic bus_abort,
    output logic remap_state,
    output logic boot_select
);

    // ================================================================
    // Helpers
    function automatic logic prot_allows(prot_t p, logic priv, logic wr);
        unique case (p)
            `PROT_NONE: prot_allows = 1'b0;
            `PROT_PRIV: prot_allows = priv;
            `PROT_USER_RO: prot_allows = priv | ~wr;
            default: prot_allows = 1'b1;
        endcase
    endfunction : prot_allows

    function automatic logic area_hit(logic [31:0] cfg, logic [31:0] a);
        logic [3:0] sz;
        logic [21:0] msk;
        sz = cfg[`PA_SIZE_LSB +: 4];
        if (sz > `PA_SIZE_MAX) begin
            sz = `PA_SIZE_MAX;
        end
        msk = 22'h3F_FFFF << (5'(sz) + 5'd10);
        area_hit = (a[27:22] == 6'h00) &&
                   (((a[21:0] ^ {cfg[21:`PA_BASE_LSB], 10'h000}) & msk) == 22'h00_0000);
    endfunction : area_hit

    // ================================================================
    // Registers
    logic remap_reg;
    logic boot_sel_reg;
    logic prot_en_reg;
    logic [31:0] prot_area_reg [N_AREAS];
    logic [31:0] prot_periph_reg;
    logic [31:0] abort_addr_reg;
    logic [1:0] abt_size_reg;
    logic [1:0] abt_type_reg;
    logic [2:0] abt_cause_reg;
    logic [1:0] abt_src_reg;
    logic [1:0] abt_sticky_reg;
    logic abt_unread_reg;

    logic wr_en;
    logic rd_en;
    logic asr_read;
    logic addr_ok;
    logic [31:0] rd_data;

    // ================================================================
    // Arbitration and request mux
    logic take;
    logic [31:0] a;
    logic wr;
    logic [1:0] sz;
    logic priv;
    logic fetch;

    assign dma_gnt = dma_req;
    assign cpu_gnt = cpu_req & ~dma_req;
    assign take = dma_req | cpu_req;
    assign a = dma_req ? dma_addr : cpu_addr;
    assign wr = dma_req ? dma_write : cpu_write;
    assign sz = dma_req ? dma_size : cpu_size;
    assign priv = dma_req ? dma_priv : cpu_priv;
    assign fetch = ~dma_req & cpu_fetch;

    // ================================================================
    // Address decode
    region_e region;
    logic [7:0] slot;
    logic [2:0] sel;
    logic [31:0] local_addr;
    logic int_undef;
    logic misaligned;
    logic prot_fail;
    logic undef;
    logic abort;
    prot_t mem_prot;
    logic area_any;

    assign slot = a[27:20];

    always_comb begin
        if (a[31:28] == `TOP_INTERNAL) begin
            region = REGION_INTERNAL;
        end else if (a[31:28] >= `TOP_EBI_FIRST && a[31:28] <= `TOP_EBI_LAST) begin
            region = REGION_EXTERNAL;
        end else if (a[31:28] == `TOP_PERIPH) begin
            region = REGION_PERIPH;
        end else begin
            region = REGION_UNDEF;
        end
    end

    // Sel bits: 0 flash, 1 SRAM, 2 ROM
    always_comb begin
        sel = 3'h0;
        int_undef = 1'b0;
        unique case (slot)
            `SLOT_AREA0: sel = remap_reg ? 3'h2 : (boot_sel_reg ? 3'h1 : 3'h4);
            `SLOT_FLASH: sel = 3'h1;
            `SLOT_SRAM: sel = 3'h2;
            `SLOT_ROM: sel = 3'h4;
            default: int_undef = 1'b1;
        endcase
    end

    // aliasing: only the memory's own address bits survive
    always_comb begin
        local_addr = a;
        if (region == REGION_INTERNAL) begin
            unique case (sel)
                3'h1: local_addr = a & ((32'h1 << FLASH_AW) - 32'h1);
                3'h2: local_addr = a & ((32'h1 << SRAM_AW) - 32'h1);
                3'h4: local_addr = a & ((32'h1 << ROM_AW) - 32'h1);
                default: local_addr = a;
            endcase
        end
    end

    always_comb begin
        mem_prot = `PROT_FULL;
        area_any = 1'b0;
        for (int i = 0; i < N_AREAS; i++) begin
            if (area_hit(prot_area_reg[i], a)) begin
                area_any = 1'b1;
                if (prot_area_reg[i][`PA_PROT_LSB +: 2] < mem_prot) begin
                    mem_prot = prot_area_reg[i][`PA_PROT_LSB +: 2];
                end
            end
        end
        if (!area_any) begin
            mem_prot = `PROT_NONE;
        end
    end

    assign misaligned = ~fetch & (((sz == `SIZE_WORD) && (a[1:0] != 2'h0)) ||
                                  ((sz == `SIZE_HALF) && a[0]));
    assign undef = (region == REGION_UNDEF) || ((region == REGION_INTERNAL) && int_undef);

    always_comb begin
        prot_fail = 1'b0;
        if (prot_en_reg && region == REGION_INTERNAL && !int_undef) begin
            prot_fail = ~prot_allows(mem_prot, priv, wr);
        end else if (prot_en_reg && region == REGION_PERIPH) begin
            prot_fail = ~prot_allows(prot_periph_reg[`PA_PROT_LSB +: 2], priv, wr);
        end
    end

    assign abort = take & (undef | misaligned | prot_fail);

    // ================================================================
    // Transfer outputs, registered one cycle after the grant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_valid <= 1'b0;
            xfer_master <= 1'b0;
            xfer_write <= 1'b0;
            xfer_size <= 2'h0;
            xfer_addr <= 32'h0000_0000;
            mem_sel <= 3'h0;
            ebi_cs <= 8'h00;
            periph_sel <= 1'b0;
        end else begin
            xfer_valid <= take & ~abort;
            xfer_master <= dma_req;
            xfer_write <= wr;
            xfer_size <= sz;
            xfer_addr <= (region == REGION_INTERNAL) ? local_addr : a;
            mem_sel <= (take && !abort && region == REGION_INTERNAL) ? sel : 3'h0;
            ebi_cs <= 8'h00;
            if (take && !abort && region == REGION_EXTERNAL) begin
                ebi_cs <= 8'h01 << (a[31:28] - `TOP_EBI_FIRST);
            end
            periph_sel <= take & ~abort & (region == REGION_PERIPH);
        end
    end

    // one abort line to every master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_abort <= 1'b0;
        end else begin
            bus_abort <= abort;
        end
    end

    // ================================================================
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign asr_read = rd_en & (paddr == `ABORT_STAT_OFF);

    always_comb begin
        addr_ok = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else if (paddr >= `PROT_AREA_FIRST_OFF && paddr <= `PROT_AREA_LAST_OFF) begin
            rd_data = prot_area_reg[4'(paddr[7:2] - 6'h04)];
        end else begin
            unique case (paddr)
                `REMAP_CTRL_OFF: rd_data = 32'h0000_0000;
                `ABORT_STAT_OFF: begin
                    rd_data[`ASR_UNDEF_BIT] = abt_cause_reg[0];
                    rd_data[`ASR_MISALIGN_BIT] = abt_cause_reg[1];
                    rd_data[`ASR_PROT_BIT] = abt_cause_reg[2];
                    rd_data[`ASR_SIZE_LSB +: 2] = abt_size_reg;
                    rd_data[`ASR_TYPE_LSB +: 2] = abt_type_reg;
                    rd_data[`ASR_SRC_LSB +: 2] = abt_src_reg;
                    rd_data[`ASR_STICKY_LSB +: 2] = abt_sticky_reg;
                end
                `ABORT_ADDR_OFF: rd_data = abort_addr_reg;
                `PROT_PERIPH_OFF: rd_data = prot_periph_reg;
                `PROT_ENABLE_OFF: rd_data = {31'h0, prot_en_reg};
                `BOOT_SELECT_OFF: rd_data = {31'h0, boot_sel_reg};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = rd_data;

    // ================================================================
    // Map control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remap_reg <= 1'b0;
        end else if (wr_en && paddr == `REMAP_CTRL_OFF && pwdata[0]) begin
            remap_reg <= ~remap_reg;
        end
    end

    // Boot selection is modelled as a volatile bit cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_sel_reg <= 1'b0;
        end else if (erase_in) begin
            boot_sel_reg <= 1'b0;
        end else if (wr_en && paddr == `BOOT_SELECT_OFF) begin
            boot_sel_reg <= pwdata[0];
        end
    end

    assign remap_state = remap_reg;
    assign boot_select = boot_sel_reg;

    // ================================================================
    // Protection registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_en_reg <= 1'b0;
            prot_periph_reg <= `PROT_RESET;
            for (int i = 0; i < N_AREAS; i++) begin
                prot_area_reg[i] <= `PROT_RESET;
            end
        end else if (wr_en) begin
            if (paddr == `PROT_ENABLE_OFF) begin
                prot_en_reg <= pwdata[0];
            end
            if (paddr == `PROT_PERIPH_OFF) begin
                prot_periph_reg <= {30'h0, pwdata[`PA_PROT_LSB +: 2]};
            end
            if (paddr >= `PROT_AREA_FIRST_OFF && paddr <= `PROT_AREA_LAST_OFF && paddr[1:0] == 2'h0) begin
                prot_area_reg[4'(paddr[7:2] - 6'h04)] <= pwdata & `PA_RW_MASK;
            end
        end
    end

    // ================================================================
    // Abort status capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_addr_reg <= 32'h0000_0000;
            abt_size_reg <= 2'h0;
            abt_type_reg <= 2'h0;
            abt_cause_reg <= 3'h0;
            abt_src_reg <= 2'h0;
        end else if (abort) begin
            abort_addr_reg <= a;
            abt_size_reg <= sz;
            abt_type_reg <= fetch ? `TYPE_FETCH : (wr ? `TYPE_WRITE : `TYPE_READ);
            abt_cause_reg <= {prot_fail, misaligned, undef};
            // one-hot source, bit 1 is the DMA master
            abt_src_reg <= {dma_req, ~dma_req};
        end
    end

    // Sticky flags keep aborts whose report was overwritten before a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abt_sticky_reg <= 2'h0;
            abt_unread_reg <= 1'b0;
        end else begin
            // set wins over the read clear
            abt_sticky_reg <= (asr_read ? 2'h0 : abt_sticky_reg) |
                              ((abort && abt_unread_reg) ? abt_src_reg : 2'h0);
            abt_unread_reg <= abort | (abt_unread_reg & ~asr_read);
        end
    end

endmodule : memory_controller

// file: testbench/memctl_chk.sv
// Assertion checker bound to the memory controller ports
`timescale 1ns/1ns
module memctl_chk #(
    parameter int SRAM_AW = 15
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Masters
    input wire logic cpu_req,
    input wire logic [31:0] cpu_addr,
    input wire logic [1:0] cpu_size,
    input wire logic cpu_fetch,
    input wire logic cpu_gnt,
    input wire logic dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic [1:0] dma_size,
    input wire logic dma_gnt,
    // Erase, slave side and status
    input wire logic erase_in,
    input wire logic xfer_valid,
    input wire logic [31:0] xfer_addr,
    input wire logic [2:0] mem_sel,
    input wire logic [7:0] ebi_cs,
    input wire logic bus_abort,
    input wire logic remap_state,
    input wire logic boot_select
);
    // ================================================================
    // Granted request as the arbiter should see it
    logic g_req, g_fetch, mis, rc_wr;
    logic [31:0] g_addr;
    logic [1:0] g_size;
    assign g_req = dma_req | cpu_req;
    assign g_addr = dma_req ? dma_addr : cpu_addr;
    assign g_size = dma_req ? dma_size : cpu_size;
    assign g_fetch = !dma_req && cpu_fetch;
    assign mis = !g_fetch && ((g_size == 2'h2 && g_addr[1:0] != 2'h0) || (g_size == 2'h1 && g_addr[0]));
    assign rc_wr = psel && penable && pwrite && paddr == 8'h00;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ================================================================
    // Assertions
    a_dma_wins: assert property (dma_req |-> dma_gnt && !cpu_gnt)
        else $error("cpu granted while dma requests");
    a_one_answer: assert property (g_req |=> xfer_valid != bus_abort)
        else $error("request not answered by exactly one of transfer or abort");
    a_idle_quiet: assert property (!g_req |=> !xfer_valid && !bus_abort)
        else $error("transfer or abort without a request");
    a_undef_abort: assert property (g_req && g_addr[31:28] inside {[4'h9:4'hE]} |=> bus_abort)
        else $error("undefined region not aborted");
    a_ebi_select: assert property (g_req && !mis && g_addr[31:28] inside {[4'h1:4'h8]}
        |=> ebi_cs == 8'h01 << ($past(g_addr[31:28]) - 4'h1))
        else $error("wrong chip select");
    a_misalign_abort: assert property (g_req && mis |=> bus_abort)
        else $error("misaligned access not aborted");
    a_fetch_exempt: assert property (cpu_gnt && cpu_fetch && cpu_addr[31:28] == 4'h1
        |=> !bus_abort && ebi_cs == 8'h01)
        else $error("instruction fetch checked for alignment");
    a_sram_alias: assert property (xfer_valid && mem_sel == 3'b010 |-> xfer_addr < (32'h1 << SRAM_AW))
        else $error("sram offset beyond memory size");
    a_mem_onehot: assert property ($onehot0(mem_sel))
        else $error("several memories selected");
    a_remap_toggle: assert property (rc_wr && pwdata[0] |=> remap_state != $past(remap_state))
        else $error("remap not toggled");
    a_remap_hold: assert property (rc_wr && !pwdata[0] |=> $stable(remap_state))
        else $error("remap changed by zero write");
    a_erase_clear: assert property (erase_in |=> !boot_select)
        else $error("erase left boot select set");

    c_contend: cover property (dma_req && cpu_req);
    c_abort: cover property (bus_abort);
    c_sram: cover property (xfer_valid && mem_sel == 3'b010);
    c_remap: cover property (rc_wr && pwdata[0]);
endmodule : memctl_chk

bind memory_controller memctl_chk #(.SRAM_AW(SRAM_AW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .cpu_req, .cpu_addr, .cpu_size, .cpu_fetch, .cpu_gnt, .dma_req, .dma_addr, .dma_size,
    .dma_gnt, .erase_in, .xfer_valid, .xfer_addr, .mem_sel, .ebi_cs, .bus_abort, .remap_state, .boot_select);

// file: testbench/master_model.sv
// Behavioural bus master holding each request until granted
`timescale 1ns/1ns
module master_model #(
    parameter bit TAKES_ABORT = 1'b1
) (
    // Clock
    input wire logic pclk,
    // Request
    output logic req,
    output logic [31:0] addr,
    output logic write,
    output logic [1:0] size,
    output logic fetch,
    output logic priv,
    // Answer
    input wire logic gnt,
    input wire logic abort
);
    logic granted;
    int n_abort;
    initial begin
        req = 1'b0;
        addr = 32'h0;
        write = 1'b0;
        size = 2'h0;
        fetch = 1'b0;
        priv = 1'b1;
        granted = 1'b0;
        n_abort = 0;
    end

    always @(posedge pclk) begin
        if (TAKES_ABORT && granted && abort === 1'b1) begin
            n_abort++;
        end
        granted <= req && gnt;
    end

    // ================================================================
    // One transfer; released address lines are inverted so stale values cannot match
    // little-endian lanes only
    task automatic issue(input logic [31:0] a, input logic w, input logic [1:0] s, input logic f,
                         input logic p, output int waited);
        waited = 0;
        @(posedge pclk);
        req <= 1'b1;
        addr <= a;
        write <= w;
        size <= s;
        fetch <= f;
        priv <= p;
        do begin
            @(posedge pclk);
            waited++;
        end while (gnt !== 1'b1);
        req <= 1'b0;
        addr <= ~a;
    endtask : issue
endmodule : master_model

// file: testbench/tb.sv
// Register and master-access testbench for the memory controller
`timescale 1ns/1ns
`include "memctl_cfg.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erase_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, xfer_addr, cpu_addr, dma_addr;
    logic rerr, cpu_req, cpu_write, cpu_fetch, cpu_priv, cpu_gnt, dma_req, dma_write, dma_priv, dma_gnt;
    logic [1:0] cpu_size, dma_size, xfer_size;
    logic xfer_valid, xfer_master, xfer_write, periph_sel, bus_abort, remap_state, boot_select;
    logic [2:0] mem_sel;
    logic [7:0] ebi_cs;
    int n_mismatch, num_checks, wd, wc;

    memory_controller uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cpu_req, .cpu_addr, .cpu_write, .cpu_size, .cpu_fetch, .cpu_priv, .cpu_gnt, .dma_req,
        .dma_addr, .dma_write, .dma_size, .dma_priv, .dma_gnt, .erase_in, .xfer_valid, .xfer_master,
        .xfer_write, .xfer_size, .xfer_addr, .mem_sel, .ebi_cs, .periph_sel, .bus_abort, .remap_state,
        .boot_select);
    master_model u_cpu (.pclk, .req(cpu_req), .addr(cpu_addr), .write(cpu_write), .size(cpu_size),
        .fetch(cpu_fetch), .priv(cpu_priv), .gnt(cpu_gnt), .abort(bus_abort));
    master_model #(.TAKES_ABORT(1'b0)) u_dma (.pclk, .req(dma_req), .addr(dma_addr), .write(dma_write),
        .size(dma_size), .fetch(), .priv(dma_priv), .gnt(dma_gnt), .abort(bus_abort));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ================================================================
    // Tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // APB transfer starting at a clock edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("prdata", rdat, exp);
    endtask : rd_chk

    task automatic acc(input bit dma, input logic [31:0] a, input logic w, input logic [1:0] s,
                       input logic f, input logic p);
        if (dma) u_dma.issue(a, w, s, f, p, wd);
        else u_cpu.issue(a, w, s, f, p, wd);
        #1;
    endtask : acc

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        end_sim();
    end

    // ================================================================
    // Scenarios
    initial begin
        {presetn, psel, penable, pwrite, erase_in} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`ABORT_STAT_OFF, 32'h0);
        rd_chk(`ABORT_ADDR_OFF, 32'h0);
        rd_chk(`PROT_AREA_FIRST_OFF, `PROT_RESET);
        apb(1'b0, 8'h0C, 32'h0);
        chk("pslverr", rerr, 1'b1);
        // Every top nibble, processor word reads
        for (int n = 0; n < 16; n++) begin
            acc(1'b0, {n[3:0], 28'h0100000}, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
            chk("bus_abort", bus_abort, n inside {[9:14]});
            chk("ebi_cs", ebi_cs, (n >= 1 && n <= 8) ? 8'h01 << (n - 1) : 8'h0);
            chk("periph_sel", periph_sel, n == 15);
            chk("mem_sel", mem_sel, n == 0 ? 3'b001 : 3'b000);
        end
        rd_chk(`ABORT_STAT_OFF, 32'h0101_0201);
        rd_chk(`ABORT_ADDR_OFF, 32'hE010_0000);
        rd_chk(`ABORT_STAT_OFF, 32'h0001_0201);
        // Boot mapping and erase
        acc(1'b0, 32'h0000_0010, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("mem_sel", mem_sel, 3'b100);
        chk("xfer_addr", xfer_addr, 32'h10);
        apb(1'b1, `BOOT_SELECT_OFF, 32'h1);
        acc(1'b0, 32'h0000_0010, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("mem_sel", mem_sel, 3'b001);
        @(posedge pclk);
        erase_in <= 1'b1;
        @(posedge pclk);
        erase_in <= 1'b0;
        #1;
        chk("boot_select", boot_select, 1'b0);
        acc(1'b0, 32'h0000_0010, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("mem_sel", mem_sel, 3'b100);
        // Remap toggling and aliasing
        apb(1'b1, `REMAP_CTRL_OFF, 32'h1);
        chk("remap_state", remap_state, 1'b1);
        acc(1'b0, 32'h0000_0010, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("mem_sel", mem_sel, 3'b010);
        acc(1'b1, 32'h0020_8004, 1'b1, `SIZE_WORD, 1'b0, 1'b1);
        chk("xfer_addr", xfer_addr, 32'h4);
        chk("xfer_size", {xfer_write, xfer_size}, 3'b110);
        acc(1'b0, 32'h0030_0010, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("mem_sel", mem_sel, 3'b100);
        apb(1'b1, `REMAP_CTRL_OFF, 32'h0);
        chk("remap_state", remap_state, 1'b1);
        apb(1'b1, `REMAP_CTRL_OFF, 32'h1);
        chk("remap_state", remap_state, 1'b0);
        // Abort status contents
        acc(1'b0, 32'h0050_0000, 1'b1, `SIZE_WORD, 1'b0, 1'b1);
        chk("bus_abort", bus_abort, 1'b1);
        rd_chk(`ABORT_STAT_OFF, 32'h0001_0601);
        rd_chk(`ABORT_ADDR_OFF, 32'h0050_0000);
        acc(1'b1, 32'h0020_0001, 1'b0, `SIZE_HALF, 1'b0, 1'b1);
        acc(1'b0, 32'h1000_0002, 1'b0, `SIZE_WORD, 1'b1, 1'b1);
        chk("ebi_cs", ebi_cs, 8'h01);
        rd_chk(`ABORT_STAT_OFF, 32'h0002_0102);
        rd_chk(`ABORT_ADDR_OFF, 32'h0020_0001);
        acc(1'b0, 32'h9000_0000, 1'b0, `SIZE_WORD, 1'b1, 1'b1);
        rd_chk(`ABORT_STAT_OFF, 32'h0001_0A01);
        // Both masters at once
        fork
            u_dma.issue(32'h2000_0000, 1'b0, `SIZE_BYTE, 1'b0, 1'b1, wd);
            u_cpu.issue(32'h3000_0000, 1'b0, `SIZE_BYTE, 1'b0, 1'b1, wc);
        join
        #1;
        chk("dma_wait", wd, 1);
        chk("cpu_wait", wc, 2);
        chk("xfer_master", xfer_master, 1'b0);
        chk("ebi_cs", ebi_cs, 8'h04);
        // Protection unit
        apb(1'b1, `PROT_ENABLE_OFF, 32'h1);
        acc(1'b0, 32'h0010_0000, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("bus_abort", bus_abort, 1'b1);
        rd_chk(`ABORT_STAT_OFF, 32'h0001_0204);
        apb(1'b1, `PROT_AREA_FIRST_OFF, 32'h0000_00C3);
        acc(1'b0, 32'h0010_0000, 1'b0, `SIZE_WORD, 1'b0, 1'b0);
        chk("mem_sel", mem_sel, 3'b001);
        apb(1'b1, `PROT_AREA_FIRST_OFF + 8'h04, 32'h0000_00C1);
        acc(1'b0, 32'h0010_0000, 1'b0, `SIZE_WORD, 1'b0, 1'b0);
        chk("bus_abort", bus_abort, 1'b1);
        acc(1'b0, 32'h0010_0000, 1'b0, `SIZE_WORD, 1'b0, 1'b1);
        chk("bus_abort", bus_abort, 1'b0);
        apb(1'b1, `PROT_AREA_LAST_OFF, 32'hFFFF_FC03);
        rd_chk(`PROT_AREA_LAST_OFF, 32'h003F_FC03);
        apb(1'b1, `ABORT_ADDR_OFF, 32'hFFFF_FFFF);
        rd_chk(`ABORT_ADDR_OFF, 32'h0010_0000);
        apb(1'b1, `PROT_ENABLE_OFF, 32'h0);
        chk("cpu_aborts", u_cpu.n_abort, 32'd10);
        end_sim();
    end
endmodule : tb
